// file: shared/cle_pkg.sv
// Package with constants and types for the code lock and encryption block
package cle_pkg;
    localparam int ADDR_W = 15;
    localparam int ENC_DEPTH = 64;
    localparam int ENC_IDX_W = 6;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [ADDR_W-1:0] SIG_ADDR_0 = 15'h0030;
    localparam logic [ADDR_W-1:0] SIG_ADDR_1 = 15'h0031;
    localparam logic [ADDR_W-1:0] SIG_ADDR_2 = 15'h0060;
    // Identification values below are arbitrary
    localparam logic [7:0] SIG_VAL_0 = 8'h11;
    localparam logic [7:0] SIG_VAL_1 = 8'h22;
    localparam logic [7:0] SIG_VAL_2 = 8'h33;
    localparam logic [2:0] LOCK_RESET = 3'h0;
    localparam logic [2:0] PROT_RESET = 3'h7;
    localparam int STROBE_SYNC_STAGES = 3;
    localparam logic [2:0] SETTLE_CYC = 3'h5;
    typedef enum logic [3:0] {
        CLE_LVL1 = 4'h1,
        CLE_LVL2 = 4'h2,
        CLE_LVL3 = 4'h4,
        CLE_LVL4 = 4'h8
    } cle_level_e;
    typedef enum logic [3:0] {
        CLE_OP_IDLE   = 4'h1,
        CLE_OP_VERIFY = 4'h2,
        CLE_OP_SIG    = 4'h4,
        CLE_OP_PROG   = 4'h8
    } cle_op_e;
endpackage : cle_pkg

// file: rtl/cle_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module cle_sync (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic       out_reg;
    logic       out_next;

    always_comb begin
        sync_next = {sync_reg[1:0], din};
        out_next  = out_reg;
        if (sync_reg[1] == sync_reg[2]) begin
            out_next = sync_reg[2];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync_reg <= 3'h0;
            out_reg  <= 1'h0;
        end else begin
            sync_reg <= sync_next;
            out_reg  <= out_next;
        end
    end

    assign dout = out_reg;
endmodule : cle_sync

// file: rtl/cle_lock.sv
// Program lock, encryption array and signature verify path
`timescale 1ns/100ps
module cle_lock
    import cle_pkg::*;
#(
    parameter bit MASK_VARIANT = 1'b0
) (
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire logic                     program_strobe_n,
    input  wire logic                     mode_verify,
    input  wire logic                     mode_signature,
    input  wire logic                     mode_prog_code,
    input  wire logic                     mode_prog_enc,
    input  wire logic [2:0]               mode_prog_lock,
    input  wire logic                     erase,
    input  wire logic [cle_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]               wdata,
    input  wire logic [7:0]               code_byte,
    input  wire logic                     external_access_select,
    input  wire logic                     code_table_read_instr,
    input  wire logic                     fetch_from_external,
    output logic [7:0]                    verify_data,
    output logic                          verify_valid,
    output logic                          code_write_en,
    output logic [7:0]                    code_write_data,
    output logic                          code_erase,
    output logic                          internal_fetch_block,
    output logic                          external_exec_block,
    output logic                          ea_effective,
    output logic [3:0]                    lock_level
);
    import cle_pkg::*;

    logic       strobe_s;
    logic       ea_s;
    logic [7:0] enc_mem [ENC_DEPTH];
    logic [7:0] enc_next [ENC_DEPTH];
    logic [2:0] prot_reg;
    logic [2:0] prot_next;
    logic [3:0] lvl_reg;
    logic [3:0] lvl_next;
    logic       strobe_d_reg;
    logic       ea_latch_reg;
    logic       ea_latch_next;
    logic       rst_seen_reg;
    logic [2:0] settle_reg;
    logic [2:0] settle_next;
    logic [7:0] vdata_reg;
    logic [7:0] vdata_next;
    logic       vvalid_reg;
    logic       vvalid_next;
    logic       cwe_reg;
    logic       cwe_next;
    logic [7:0] cwd_reg;
    logic [7:0] cwd_next;
    logic       cer_reg;
    logic       ifb_reg;
    logic       ifb_next;
    logic       eeb_reg;
    logic       eeb_next;
    logic       eaeff_reg;
    logic       eaeff_next;
    logic       pulse;
    logic       prog_ok;
    logic [ENC_IDX_W-1:0] idx;
    cle_level_e lvl_cur;

    cle_sync u_sync_strobe (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (program_strobe_n),
        .dout     (strobe_s)
    );

    cle_sync u_sync_ea (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (external_access_select),
        .dout     (ea_s)
    );

    assign pulse   = strobe_d_reg & ~strobe_s;
    assign idx     = addr[ENC_IDX_W-1:0];
    assign lvl_cur = cle_level_e'(lvl_reg);
    assign prog_ok = (lvl_cur == CLE_LVL1);

    // Decode of held lock bits; programmed cell reads as zero
    function automatic logic [3:0] decode(input logic [2:0] p);
        logic [3:0] r;
        r = CLE_LVL4;
        if (MASK_VARIANT) begin
            r = p[0] ? CLE_LVL1 : CLE_LVL2;
        end else begin
            case (p)
                3'h7: r = CLE_LVL1;
                3'h6: r = CLE_LVL2;
                3'h4: r = CLE_LVL3;
                3'h0: r = CLE_LVL4;
                default: r = CLE_LVL4;
            endcase
        end
        return r;
    endfunction : decode

    // Nonvolatile array updates: programming and erase
    generate
        for (genvar i = 0; i < ENC_DEPTH; i++) begin : g_enc
            always_comb begin
                enc_next[i] = enc_mem[i];
                if (erase) begin
                    enc_next[i] = ERASED_BYTE;
                end else if (pulse && mode_prog_enc && prog_ok
                             && !MASK_VARIANT
                             && idx == ENC_IDX_W'(i)) begin
                    enc_next[i] = enc_mem[i] & wdata;
                end
            end
            // Nonvolatile cells keep their contents through reset
            always_ff @(posedge core_clk) begin
                enc_mem[i] <= enc_next[i];
            end
        end
    endgenerate

    always_comb begin
        prot_next = prot_reg;
        if (erase) begin
            prot_next = PROT_RESET;
        end else if (pulse && !mode_prog_code && !mode_prog_enc) begin
            prot_next = prot_reg & ~mode_prog_lock;
        end
    end

    // Lock bits survive reset so a programmed level takes hold
    always_ff @(posedge core_clk) begin
        prot_reg <= prot_next;
    end

    // Level is captured once after reset release, the EA latch on each of the first five cycles
    always_comb begin
        lvl_next      = lvl_reg;
        ea_latch_next = ea_latch_reg;
        settle_next   = settle_reg;
        if (!rst_seen_reg) begin
            lvl_next      = decode(prot_reg);
        end
        // EA pin is taken every cycle until settle_reg reaches SETTLE_CYC, then held
        if (settle_reg != SETTLE_CYC) begin
            settle_next   = settle_reg + 3'h1;
            ea_latch_next = ea_s;
        end
    end

    always_comb begin
        vdata_next  = 8'hFF;
        vvalid_next = 1'b0;
        if (mode_signature) begin
            vvalid_next = 1'b1;
            case (addr)
                SIG_ADDR_0: vdata_next = SIG_VAL_0;
                SIG_ADDR_1: vdata_next = SIG_VAL_1;
                SIG_ADDR_2: vdata_next = SIG_VAL_2;
                default:    vdata_next = 8'hFF;
            endcase
        end else if (mode_verify) begin
            if (lvl_cur == CLE_LVL1 || lvl_cur == CLE_LVL2) begin
                vvalid_next = 1'b1;
                vdata_next  = ~(code_byte ^ enc_mem[idx]);
            end
        end
        cwe_next   = pulse && mode_prog_code && prog_ok && !erase;
        cwd_next   = wdata;
        ifb_next   = (lvl_cur != CLE_LVL1) && code_table_read_instr
                     && fetch_from_external;
        eeb_next   = (lvl_cur == CLE_LVL4) && fetch_from_external;
        eaeff_next = (lvl_cur == CLE_LVL1) ? ea_s : ea_latch_reg;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lvl_reg      <= CLE_LVL4;
            ea_latch_reg <= 1'b0;
            rst_seen_reg <= 1'b0;
            settle_reg   <= 3'h0;
            strobe_d_reg <= 1'b0;
            vdata_reg    <= 8'hFF;
            vvalid_reg   <= 1'b0;
            cwe_reg      <= 1'b0;
            cwd_reg      <= 8'hFF;
            cer_reg      <= 1'b0;
            ifb_reg      <= 1'b1;
            eeb_reg      <= 1'b1;
            eaeff_reg    <= 1'b0;
        end else begin
            lvl_reg      <= lvl_next;
            ea_latch_reg <= ea_latch_next;
            rst_seen_reg <= 1'b1;
            settle_reg   <= settle_next;
            strobe_d_reg <= strobe_s;
            vdata_reg    <= vdata_next;
            vvalid_reg   <= vvalid_next;
            cwe_reg      <= cwe_next;
            cwd_reg      <= cwd_next;
            cer_reg      <= erase;
            ifb_reg      <= ifb_next;
            eeb_reg      <= eeb_next;
            eaeff_reg    <= eaeff_next;
        end
    end

    assign verify_data          = vdata_reg;
    assign verify_valid         = vvalid_reg;
    assign code_write_en        = cwe_reg;
    assign code_write_data      = cwd_reg;
    assign code_erase           = cer_reg;
    assign internal_fetch_block = ifb_reg;
    assign external_exec_block  = eeb_reg;
    assign ea_effective         = eaeff_reg;
    assign lock_level           = lvl_reg;

    AST_NO_WRITE_LOCKED: assert property (@(posedge core_clk) disable iff (!rstn)
        rst_seen_reg && lvl_cur != CLE_LVL1 |=> !code_write_en)
        else $error("code write while locked");
    AST_VERIFY_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
        rst_seen_reg && mode_verify && !mode_signature
        && (lvl_cur == CLE_LVL3 || lvl_cur == CLE_LVL4)
        |=> !verify_valid)
        else $error("verify not disabled");
    AST_XNOR: assert property (@(posedge core_clk) disable iff (!rstn)
        mode_verify && !mode_signature && lvl_cur == CLE_LVL1
        |=> verify_data == ~($past(code_byte) ^ $past(enc_mem[idx])))
        else $error("verify byte wrong");
    AST_EXT_BLOCK: assert property (@(posedge core_clk) disable iff (!rstn)
        rst_seen_reg && lvl_cur == CLE_LVL4 && fetch_from_external
        |=> external_exec_block)
        else $error("external execution not blocked");
    AST_TABLE_BLOCK: assert property (@(posedge core_clk) disable iff (!rstn)
        rst_seen_reg && lvl_cur == CLE_LVL2 && code_table_read_instr
        && fetch_from_external |=> internal_fetch_block)
        else $error("table read not blocked");
    AST_LEVEL_HELD: assert property (@(posedge core_clk) disable iff (!rstn)
        rst_seen_reg && $past(rst_seen_reg) |-> $stable(lvl_reg))
        else $error("lock level changed");
    AST_EA_LATCHED: assert property (@(posedge core_clk) disable iff (!rstn)
        rst_seen_reg && settle_reg == SETTLE_CYC && lvl_cur != CLE_LVL1
        |=> ea_effective == ea_latch_reg)
        else $error("ea not latched");
    AST_EA_FOLLOW: assert property (@(posedge core_clk) disable iff (!rstn)
        rst_seen_reg && lvl_cur == CLE_LVL1
        |=> ea_effective == $past(ea_s))
        else $error("ea not followed");
    AST_ENC_LOCKED: assert property (@(posedge core_clk) disable iff (!rstn)
        rst_seen_reg && !prog_ok && !erase
        |=> enc_mem[$past(idx)] == $past(enc_mem[idx]))
        else $error("encryption byte changed while locked");
    AST_LOCK_ONE_WAY: assert property (@(posedge core_clk) disable iff (!rstn)
        !erase |=> (prot_reg & ~$past(prot_reg)) == 3'h0)
        else $error("lock bit returned without erase");
    AST_SIG: assert property (@(posedge core_clk) disable iff (!rstn)
        mode_signature && addr == SIG_ADDR_0
        |=> verify_valid && verify_data == SIG_VAL_0)
        else $error("signature wrong");
    AST_ERASE: assert property (@(posedge core_clk) disable iff (!rstn)
        erase |=> prot_reg == PROT_RESET && enc_mem[0] == ERASED_BYTE)
        else $error("erase incomplete");

    COV_VERIFY: cover property (@(posedge core_clk) verify_valid && mode_verify);
    COV_SIG: cover property (@(posedge core_clk) verify_valid && mode_signature);
    COV_WRITE: cover property (@(posedge core_clk) code_write_en);
    COV_LOCKED: cover property (@(posedge core_clk) lvl_cur == CLE_LVL4);
    COV_LEVEL2: cover property (@(posedge core_clk) lvl_cur == CLE_LVL2);
endmodule : cle_lock

// file: verification/cle_prog_model.sv
// Programmer model that pulses the programming strobe
`timescale 1ns/100ps
module cle_prog_model (
    input  wire logic core_clk,
    output logic      program_strobe_n
);
    initial program_strobe_n = 1'b1;

    // Six cycles low and high so the strobe synchroniser sees every pulse
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge core_clk);
            program_strobe_n <= 1'b0;
            repeat (6) @(posedge core_clk);
            program_strobe_n <= 1'b1;
            repeat (6) @(posedge core_clk);
        end
    endtask : pulses
endmodule : cle_prog_model

// file: verification/tb_cle_lock.sv
// Self-checking testbench for the code lock and encryption block
`timescale 1ns/100ps
module tb_cle_lock;
    import cle_pkg::*;
    localparam int LIMIT = 5000;
    logic              core_clk, rstn, program_strobe_n, erase;
    logic              mode_verify, mode_signature, mode_prog_code;
    logic              mode_prog_enc, external_access_select;
    logic              code_table_read_instr, fetch_from_external;
    logic [2:0]        mode_prog_lock;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata, code_byte, verify_data, code_write_data;
    logic              verify_valid, code_write_en, code_erase;
    logic              internal_fetch_block, external_exec_block;
    logic              ea_effective;
    logic [3:0]        lock_level;
    logic [7:0]        enc [ENC_DEPTH];
    logic [7:0]        vq [$];
    logic [7:0]        wq [$];
    int                n_mismatch = 0;
    int                num_checks = 0;
    int                cyc = 0;

    cle_lock i_cle_lock (
        .core_clk, .rstn, .program_strobe_n, .mode_verify, .mode_signature,
        .mode_prog_code, .mode_prog_enc, .mode_prog_lock, .erase, .addr,
        .wdata, .code_byte, .external_access_select, .code_table_read_instr,
        .fetch_from_external, .verify_data, .verify_valid, .code_write_en,
        .code_write_data, .code_erase, .internal_fetch_block,
        .external_exec_block, .ea_effective, .lock_level
    );
    cle_prog_model i_cle_prog_model (.core_clk, .program_strobe_n);

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // One verify or signature request per edge, result noted in the queue
    task automatic look(input logic sig, input logic [ADDR_W-1:0] a,
                        input logic [7:0] cb, input logic [7:0] exp);
        @(posedge core_clk);
        mode_signature <= sig;
        mode_verify    <= ~sig;
        addr           <= a;
        code_byte      <= cb;
        vq.push_back(exp);
    endtask : look

    task automatic idle(input int n);
        @(posedge core_clk);
        mode_verify    <= 1'b0;
        mode_signature <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : idle

    // Back-to-back verifies, half of them on one encryption index
    task automatic burst(input logic [5:0] hot);
        logic [ADDR_W-1:0] a;
        logic [7:0]        cb;
        for (int k = 0; k < 8; k++) begin
            a = ADDR_W'($urandom);
            cb = (k == 0) ? 8'hFF : 8'($urandom);
            if (k < 4) a[5:0] = hot;
            look(1'b0, a, cb, ~(cb ^ enc[a[5:0]]));
        end
        idle(4);
    endtask : burst

    task automatic prog(input logic [2:0] kind, input logic [7:0] d,
                        input int n, input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        mode_prog_code <= kind[0];
        mode_prog_enc  <= kind[1];
        mode_prog_lock <= kind[2] ? d[2:0] : 3'h0;
        addr           <= a;
        wdata          <= d;
        i_cle_prog_model.pulses(n);
        repeat (8) @(posedge core_clk);
        mode_prog_code <= 1'b0;
        mode_prog_enc  <= 1'b0;
        mode_prog_lock <= 3'h0;
    endtask : prog

    // Reset pulse; the level is taken again from the held lock bits
    task automatic reboot();
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask : reboot

    // Verify must stay silent at the upper levels
    task automatic no_verify();
        @(posedge core_clk);
        mode_verify <= 1'b1;
        code_byte   <= 8'($urandom);
        repeat (4) @(posedge core_clk);
        check("verify_valid", {7'h0, verify_valid}, 8'h00);
        check("verify_data", verify_data, 8'hFF);
        mode_verify <= 1'b0;
    endtask : no_verify

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin : mon
        logic [7:0] e;
        cyc = cyc + 1;
        if (rstn === 1'b1 && verify_valid === 1'b1) begin
            e = (vq.size() > 0) ? vq.pop_front() : 8'hXX;
            check("verify_data", verify_data, e);
        end
        if (rstn === 1'b1 && code_write_en === 1'b1) begin
            e = (wq.size() > 0) ? wq.pop_front() : 8'hXX;
            check("code_write_data", code_write_data, e);
        end
        if (cyc == LIMIT) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin : main
        logic [5:0] idx;
        logic [7:0] d;
        {rstn, erase, mode_verify, mode_signature, mode_prog_code} = '0;
        {mode_prog_enc, mode_prog_lock, addr, wdata, code_byte} = '0;
        // Erase during reset gives the cells a known erased state
        erase = 1'b1;
        external_access_select = 1'b1;
        code_table_read_instr = 1'b1;
        fetch_from_external = 1'b1;
        foreach (enc[i]) enc[i] = ERASED_BYTE;
        void'($urandom(32'hA05B));
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        erase <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("lock_level", {4'h0, lock_level}, {4'h0, CLE_LVL1});
        check("fetch_block", {7'h0, internal_fetch_block}, 8'h00);
        check("exec_block", {7'h0, external_exec_block}, 8'h00);
        external_access_select <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("ea_effective", {7'h0, ea_effective}, 8'h00);
        burst(6'h3F);
        for (int k = 0; k < 2; k++) begin
            idx = (k == 0) ? 6'h3F : 6'($urandom);
            d = 8'($urandom) & 8'hFE;
            enc[idx] = enc[idx] & d;
            prog(3'b010, d, 25, ADDR_W'(idx));
        end
        burst(6'h3F);
        look(1'b1, SIG_ADDR_0, 8'($urandom), SIG_VAL_0);
        look(1'b1, SIG_ADDR_1, 8'($urandom), SIG_VAL_1);
        look(1'b1, SIG_ADDR_2, 8'($urandom), SIG_VAL_2);
        idle(4);
        for (int k = 0; k < 3; k++) begin
            d = (k == 1) ? 8'h01 : 8'($urandom);
            if (k != 1) repeat (5) wq.push_back(d);
            prog((k == 1) ? 3'b100 : 3'b001, d, (k == 1) ? 25 : 5,
                 ADDR_W'($urandom));
        end
        check("lock_level", {4'h0, lock_level}, {4'h0, CLE_LVL1});
        external_access_select <= 1'b1;
        reboot();
        external_access_select <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("lock_level", {4'h0, lock_level}, {4'h0, CLE_LVL2});
        check("ea_effective", {7'h0, ea_effective}, 8'h01);
        check("fetch_block", {7'h0, internal_fetch_block}, 8'h01);
        check("exec_block", {7'h0, external_exec_block}, 8'h00);
        code_table_read_instr <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("fetch_block", {7'h0, internal_fetch_block}, 8'h00);
        code_table_read_instr <= 1'b1;
        prog(3'b001, 8'($urandom), 5, ADDR_W'($urandom));
        burst(6'h3F);
        prog(3'b100, 8'h02, 25, ADDR_W'($urandom));
        reboot();
        check("lock_level", {4'h0, lock_level}, {4'h0, CLE_LVL3});
        check("exec_block", {7'h0, external_exec_block}, 8'h00);
        no_verify();
        prog(3'b100, 8'h04, 25, ADDR_W'($urandom));
        reboot();
        check("lock_level", {4'h0, lock_level}, {4'h0, CLE_LVL4});
        check("exec_block", {7'h0, external_exec_block}, 8'h01);
        no_verify();
        @(posedge core_clk);
        erase <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("code_erase", {7'h0, code_erase}, 8'h01);
        erase <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("code_erase", {7'h0, code_erase}, 8'h00);
        foreach (enc[i]) enc[i] = ERASED_BYTE;
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("lock_level", {4'h0, lock_level}, {4'h0, CLE_LVL4});
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("lock_level", {4'h0, lock_level}, {4'h0, CLE_LVL1});
        burst(6'h3F);
        repeat (10) @(posedge core_clk);
        check("pending", 8'(vq.size() + wq.size()), 8'h00);
        stop_test();
    end
endmodule : tb_cle_lock
